//--- hw/tmb_defs.svh
// Constant definitions for the four-timer bank
// What this block does
// - Four 16-bit timers, two classic, two reload
// - Classic modes 13, 16, 8-reload; split timer0
// - Reload timers: one 16-bit or two 8-bit
// - Classic clock from five sources
// - Select bit picks prescaled or system clock
// - Reload timers: sysclk, sysclk/12, ext/8
// - Counter mode counts pin falling edges
// - Count events up to quarter system clock
// - Timers raise periodic interrupt requests
// - Prescale 00=/12 01=/4 10=/48 11=ext/8
// - Run and gate condition enable counting
// - 13-bit wrap sets overflow flag
// - Mode 2 overflow reloads low from high
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH
// Register byte addresses
`define TMB_A_CTRL    12'h000
`define TMB_A_MODE    12'h004
`define TMB_A_CLK     12'h008
`define TMB_A_STAT    12'h00C
`define TMB_A_MASK    12'h010
`define TMB_A_T0      12'h014
`define TMB_A_T1      12'h018
`define TMB_A_T2      12'h01C
`define TMB_A_T3      12'h020
`define TMB_A_R2      12'h024
`define TMB_A_R3      12'h028
// Prescale divisors
`define TMB_DIV12     8'd12
`define TMB_DIV4      8'd4
`define TMB_DIV48     8'd48
`define TMB_DIV8      8'd8
// Field positions
`define TMB_CLK_SCA   1:0
`define TMB_CLK_T0M   2
`define TMB_CLK_T1M   3
`define TMB_CLK_T2SRC 5:4
`define TMB_CLK_T3SRC 7:6
`define TMB_CTRL_T2RUN 8
`define TMB_CTRL_T3RUN 9
`define TMB_RST_VAL   32'h0000_0000
`endif

//--- hw/tmb_pkg.sv
// Package of types for the four-timer bank
package tmb_pkg;
  // Classic timer modes
  typedef enum logic [1:0] {
    TMB_M13, TMB_M16, TMB_M8R, TMB_MSPLIT
  } tmb_mode_t;
  // Bus slave data-phase states
  typedef enum logic [0:0] {TMB_IDLE, TMB_DATA} tmb_bus_t;
endpackage

//--- hw/tmb_edge.sv
// Two-stage synchroniser with falling edge detector
`timescale 1ns/10ps
`default_nettype none
module tmb_edge (
  input  wire logic clk,    // System clock
  input  wire logic rst,    // Synchronous reset
  input  wire logic ce,     // Clock enable
  input  wire logic din,    // Asynchronous pin
  output logic      lvl,    // Synchronised level
  output logic      fall    // One-cycle falling pulse
);
  // ------------------------------------------------
  // State
  // ------------------------------------------------
  typedef struct packed {
    logic s1;  // First stage, read by s2 only
    logic s2;  // Second stage
    logic s3;  // Previous sample
  } tmb_edge_st_t;
  tmb_edge_st_t st_reg;
  tmb_edge_st_t st_next;
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end
  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign lvl = st_reg.s2;
  assign fall = ce & st_reg.s3 & ~st_reg.s2;
endmodule // tmb_edge
`default_nettype wire

//--- hw/tmb_top.sv
// Four-timer bank with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.svh"
module tmb_top #(
  parameter int PW = 16  // Timer width
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        TIMER0_EVENT_PIN,
  input  wire logic        TIMER1_EVENT_PIN,
  input  wire logic        TIMER0_GATE_INPUT,
  input  wire logic        TIMER1_GATE_INPUT,
  input  wire logic        EXT_OSC_CLK,
  output logic             IRQ
);
  import tmb_pkg::*;
  if (PW != 16) begin : g_pw_chk
    $error("tmb_top supports PW of 16 only");
  end
  // ------------------------------------------------
  // State
  // ------------------------------------------------
  typedef struct packed {
    tmb_bus_t    bus;        // Data phase pending
    logic [11:0] addr;       // Latched address
    logic        wr;         // Latched write
    logic [31:0] rdata;      // Read data register
    logic [9:0]  ctrl;       // Run/gate/polarity/counter
    logic [7:0]  mode;       // Modes and split bits
    logic [7:0]  clk;        // Clock selection
    logic [5:0]  stat;       // Sticky overflow flags
    logic [5:0]  mask;       // Interrupt enables
    logic [15:0] t0;         // Timer 0 count
    logic [15:0] t1;         // Timer 1 count
    logic [15:0] t2;         // Timer 2 count
    logic [15:0] t3;         // Timer 3 count
    logic [15:0] r2;         // Timer 2 reload
    logic [15:0] r3;         // Timer 3 reload
    logic [7:0]  pre;        // Prescale counter
    logic [7:0]  d12;        // Divide-by-12 counter
    logic [7:0]  x8;         // External divide-by-8
  } tmb_st_t;
  tmb_st_t st_reg;
  tmb_st_t st_next;
  // ------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------
  logic [4:0] pin_in;    // Raw pins
  logic [4:0] pin_lvl;   // Synchronised levels
  logic [4:0] pin_fall;  // Falling pulses
  assign pin_in = {EXT_OSC_CLK, TIMER1_GATE_INPUT, TIMER0_GATE_INPUT,
                   TIMER1_EVENT_PIN, TIMER0_EVENT_PIN};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      tmb_edge u_edge (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .ce   (CLK_EN),
        .din  (pin_in[gi]),
        .lvl  (pin_lvl[gi]),
        .fall (pin_fall[gi])
      );
    end
  endgenerate
  // ------------------------------------------------
  // Clock ticks
  // ------------------------------------------------
  logic [7:0] pre_div;  // Chosen prescale divisor
  logic       pre_ext;  // Prescale from external clock
  logic       pre_tick; // Prescaled clock tick
  logic       d12_tick; // System clock / 12
  logic       x8_tick;  // External clock / 8
  logic [1:0] sca;      // Prescale field
  assign sca = st_reg.clk[`TMB_CLK_SCA];
  always_comb begin
    pre_ext = 1'b0;
    case (sca)
      2'b00:   pre_div = `TMB_DIV12;
      2'b01:   pre_div = `TMB_DIV4;
      2'b10:   pre_div = `TMB_DIV48;
      default: begin
        pre_div = `TMB_DIV8;
        pre_ext = 1'b1;
      end
    endcase
  end
  assign x8_tick  = pin_fall[4] && (st_reg.x8 == `TMB_DIV8 - 8'd1);
  assign d12_tick = (st_reg.d12 == `TMB_DIV12 - 8'd1);
  assign pre_tick = pre_ext ? x8_tick
                            : (st_reg.pre >= pre_div - 8'd1);
  // ------------------------------------------------
  // Classic timer enables
  // ------------------------------------------------
  // ctrl bits per timer i: [4i]=run [4i+1]=hw gate
  // [4i+2]=gate polarity [4i+3]=counter mode
  logic [1:0] cls_run;   // Enabled by run and gate
  logic [1:0] cls_tick;  // Increment strobe
  logic [1:0] sys_sel;   // System clock select
  assign sys_sel = {st_reg.clk[`TMB_CLK_T1M], st_reg.clk[`TMB_CLK_T0M]};
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cls
      assign cls_run[gi] = st_reg.ctrl[4*gi] &&
        (!st_reg.ctrl[4*gi+1] ||
         (pin_lvl[2+gi] == st_reg.ctrl[4*gi+2]));
      // source choice, edges at up to quarter rate
      assign cls_tick[gi] = cls_run[gi] &&
        (st_reg.ctrl[4*gi+3] ? pin_fall[gi]
                             : (sys_sel[gi] ? CLK_EN : pre_tick));
    end
  endgenerate
  // ------------------------------------------------
  // Reload timer ticks
  // ------------------------------------------------
  // source 0 sysclk, 1 /12, 2+ ext/8
  function automatic logic src_tick(input logic [1:0] s,
                                    input logic d12,
                                    input logic x8);
    case (s)
      2'd0:    src_tick = 1'b1;
      2'd1:    src_tick = d12;
      default: src_tick = x8;
    endcase
  endfunction
  logic t2_tick;  // Timer 2 tick
  logic t3_tick;  // Timer 3 tick
  assign t2_tick = st_reg.ctrl[`TMB_CTRL_T2RUN] &&
                   src_tick(st_reg.clk[`TMB_CLK_T2SRC], d12_tick, x8_tick);
  assign t3_tick = st_reg.ctrl[`TMB_CTRL_T3RUN] &&
                   src_tick(st_reg.clk[`TMB_CLK_T3SRC], d12_tick, x8_tick);
  // ------------------------------------------------
  // Bus decode
  // ------------------------------------------------
  logic        acc;    // Address phase taken
  logic        wr_now; // Write data phase
  logic [31:0] rd_mux; // Read value
  logic [5:0]  ev;     // Overflow events this cycle
  tmb_mode_t   m0;     // Timer 0 mode
  tmb_mode_t   m1;     // Timer 1 mode
  assign m0 = tmb_mode_t'(st_reg.mode[1:0]);
  assign m1 = tmb_mode_t'(st_reg.mode[3:2]);
  assign acc = HSEL && HREADY && HTRANS[1];
  assign wr_now = (st_reg.bus == TMB_DATA) && st_reg.wr;
  // Read mux
  always_comb begin
    case (HADDR[11:0])
      `TMB_A_CTRL: rd_mux = {22'h00_0000, st_reg.ctrl};
      `TMB_A_MODE: rd_mux = {24'h00_0000, st_reg.mode};
      `TMB_A_CLK:  rd_mux = {24'h00_0000, st_reg.clk};
      `TMB_A_STAT: rd_mux = {26'h000_0000, st_reg.stat};
      `TMB_A_MASK: rd_mux = {26'h000_0000, st_reg.mask};
      `TMB_A_T0:   rd_mux = {16'h0000, st_reg.t0};
      `TMB_A_T1:   rd_mux = {16'h0000, st_reg.t1};
      `TMB_A_T2:   rd_mux = {16'h0000, st_reg.t2};
      `TMB_A_T3:   rd_mux = {16'h0000, st_reg.t3};
      `TMB_A_R2:   rd_mux = {16'h0000, st_reg.r2};
      `TMB_A_R3:   rd_mux = {16'h0000, st_reg.r3};
      default:     rd_mux = `TMB_RST_VAL;
    endcase
  end
  // ------------------------------------------------
  // Next state
  // ------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ev = 6'h00;
    // Bus phases
    st_next.bus = acc ? TMB_DATA : TMB_IDLE;
    if (acc) begin
      st_next.addr = HADDR[11:0];
      st_next.wr = HWRITE;
      st_next.rdata = rd_mux;
    end
    // Divider counters
    st_next.pre = pre_tick || pre_ext ? 8'h00 : st_reg.pre + 8'd1;
    st_next.d12 = d12_tick ? 8'h00 : st_reg.d12 + 8'd1;
    if (pin_fall[4]) begin
      st_next.x8 = x8_tick ? 8'h00 : st_reg.x8 + 8'd1;
    end
    if (cls_tick[0]) begin
      case (m0)
        TMB_M13: begin
          st_next.t0 = {st_reg.t0[15:8] + {7'h00, &st_reg.t0[4:0]},
                        3'b000, st_reg.t0[4:0] + 5'd1};
          ev[0] = (&st_reg.t0[15:8]) && (&st_reg.t0[4:0]);
        end
        TMB_M16: begin
          st_next.t0 = st_reg.t0 + 16'd1;
          ev[0] = &st_reg.t0;
        end
        TMB_M8R: begin
          st_next.t0[7:0] = (&st_reg.t0[7:0]) ? st_reg.t0[15:8]
                                               : st_reg.t0[7:0] + 8'd1;
          ev[0] = &st_reg.t0[7:0];
        end
        default: begin
          st_next.t0[7:0] = st_reg.t0[7:0] + 8'd1;
          ev[0] = &st_reg.t0[7:0];
        end
      endcase
    end
    // split high half uses timer 1 run bit
    if (m0 == TMB_MSPLIT && st_reg.ctrl[4] && (sys_sel[0] ? CLK_EN
                                                        : pre_tick)) begin
      st_next.t0[15:8] = st_reg.t0[15:8] + 8'd1;
      ev[1] = &st_reg.t0[15:8];
    end
    // timer 1 has no split; split stops it
    if (cls_tick[1] && m0 != TMB_MSPLIT) begin
      case (m1)
        TMB_M13: begin
          st_next.t1 = {st_reg.t1[15:8] + {7'h00, &st_reg.t1[4:0]},
                        3'b000, st_reg.t1[4:0] + 5'd1};
          ev[1] = (&st_reg.t1[15:8]) && (&st_reg.t1[4:0]);
        end
        TMB_M8R: begin
          st_next.t1[7:0] = (&st_reg.t1[7:0]) ? st_reg.t1[15:8]
                                               : st_reg.t1[7:0] + 8'd1;
          ev[1] = &st_reg.t1[7:0];
        end
        default: begin
          st_next.t1 = st_reg.t1 + 16'd1;
          ev[1] = &st_reg.t1;
        end
      endcase
    end
    // timer 2 one 16-bit or two 8-bit reloads
    if (t2_tick) begin
      if (st_reg.mode[4]) begin
        st_next.t2[7:0] = (&st_reg.t2[7:0]) ? st_reg.r2[7:0]
                                             : st_reg.t2[7:0] + 8'd1;
        st_next.t2[15:8] = (&st_reg.t2[15:8]) ? st_reg.r2[15:8]
                                               : st_reg.t2[15:8] + 8'd1;
        ev[2] = &st_reg.t2[7:0];
        ev[3] = &st_reg.t2[15:8];
      end else begin
        st_next.t2 = (&st_reg.t2) ? st_reg.r2 : st_reg.t2 + 16'd1;
        ev[2] = &st_reg.t2;
      end
    end
    if (t3_tick) begin
      if (st_reg.mode[5]) begin
        st_next.t3[7:0] = (&st_reg.t3[7:0]) ? st_reg.r3[7:0]
                                             : st_reg.t3[7:0] + 8'd1;
        st_next.t3[15:8] = (&st_reg.t3[15:8]) ? st_reg.r3[15:8]
                                               : st_reg.t3[15:8] + 8'd1;
        ev[4] = &st_reg.t3[7:0];
        ev[5] = &st_reg.t3[15:8];
      end else begin
        st_next.t3 = (&st_reg.t3) ? st_reg.r3 : st_reg.t3 + 16'd1;
        ev[4] = &st_reg.t3;
      end
    end
    // Register writes
    if (wr_now) begin
      case (st_reg.addr)
        `TMB_A_CTRL: st_next.ctrl = HWDATA[9:0];
        `TMB_A_MODE: st_next.mode = HWDATA[7:0];
        `TMB_A_CLK:  st_next.clk = HWDATA[7:0];
        `TMB_A_STAT: st_next.stat = st_reg.stat & ~HWDATA[5:0];
        `TMB_A_MASK: st_next.mask = HWDATA[5:0];
        `TMB_A_T0:   st_next.t0 = HWDATA[15:0];
        `TMB_A_T1:   st_next.t1 = HWDATA[15:0];
        `TMB_A_T2:   st_next.t2 = HWDATA[15:0];
        `TMB_A_T3:   st_next.t3 = HWDATA[15:0];
        `TMB_A_R2:   st_next.r2 = HWDATA[15:0];
        `TMB_A_R3:   st_next.r3 = HWDATA[15:0];
        default: ;
      endcase
    end
    st_next.stat = st_next.stat | ev;
  end
  // ------------------------------------------------
  // State register
  // ------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end
  // Outputs
  assign HRDATA = st_reg.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(st_reg.stat & st_reg.mask);
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  // counter increments on edge
  t0_count_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && cls_tick[0] && m0 == TMB_M16 && st_reg.ctrl[3] && !wr_now
      |=> st_reg.t0 == $past(st_reg.t0) + 16'd1)
    else $error("timer0 count missed an edge");
  gate_hold_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && !st_reg.ctrl[0] && !wr_now && m0 != TMB_MSPLIT
      |=> st_reg.t0 == $past(st_reg.t0))
    else $error("timer0 moved while stopped");
  mode2_rel_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && cls_tick[0] && m0 == TMB_M8R && &st_reg.t0[7:0] && !wr_now
      |=> st_reg.t0[7:0] == $past(st_reg.t0[15:8]) && st_reg.stat[0])
    else $error("mode2 reload wrong");
  wrap13_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && cls_tick[0] && m0 == TMB_M13 && st_reg.t0 == 16'hFF1F
      |=> st_reg.stat[0])
    else $error("13-bit overflow not flagged");
  pre4_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && sca == 2'b01 && pre_tick
      ##1 (CLK_EN && sca == 2'b01) [*4] |-> pre_tick)
    else $error("prescale by four wrong");
  d12_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_reg.d12 < `TMB_DIV12)
    else $error("divide by twelve overran");
  t2_rel_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && t2_tick && !st_reg.mode[4] && &st_reg.t2 && !wr_now
      |=> st_reg.t2 == $past(st_reg.r2))
    else $error("timer2 reload wrong");
  irq_lvl_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && ev[0] && st_reg.mask[0] |=> IRQ)
    else $error("interrupt not raised");
endmodule // tmb_top
`default_nettype wire

//--- bench/tmb_pin_model.sv
// Pin-side model: event pins, gate pins and external oscillator
`timescale 1ns/10ps
`default_nettype none
module tmb_pin_model (
  input  wire logic clk,    // System clock
  output logic      ev0,    // Timer0 event pin, idles high
  output logic      ev1,    // Timer1 event pin, idles high
  output logic      timer0_hw_gating,  // Timer0 gate pin
  output logic      gate1,  // Timer1 gate pin
  output logic      osc     // External oscillator
);
  logic [1:0] osc_cnt;      // Oscillator phase counter

  initial begin
    ev0     = 1'b1;
    ev1     = 1'b1;
    timer0_hw_gating   = 1'b0;
    gate1   = 1'b0;
    osc_cnt = 2'h0;
  end

  // Free-running oscillator, four system clocks a period
  always @(posedge clk) osc_cnt <= osc_cnt + 2'h1;
  assign osc = osc_cnt[1];

  // Both gate pins to one level
  task automatic gate(input logic v);
    timer0_hw_gating <= v;
    gate1 <= v;
  endtask

  // uneven pulses, each level held two clocks or more
  task automatic pulses(input logic sel, input int n, input int h);
    for (int i = 0; i < n; i++) begin
      if (sel) ev1 <= 1'b0;
      else ev0 <= 1'b0;
      repeat (h + i % 3) @(posedge clk);
      if (sel) ev1 <= 1'b1;
      else ev0 <= 1'b1;
      repeat (h) @(posedge clk);
    end
  endtask
endmodule // tmb_pin_model
`default_nettype wire

//--- bench/timer_bank_clocking_and_modes_tb_top.sv
// Self-checking testbench of the four-timer bank
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.svh"
module timer_bank_clocking_and_modes_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk = 1'b0;  // System clock
  logic        sys_rst = 1'b1;  // Synchronous reset
  logic        clk_en  = 1'b1;  // Global tick enable
  logic        hsel    = 1'b0;  // Slave select
  logic [31:0] haddr   = '0;    // Bus address
  logic [1:0]  htrans  = '0;    // Transfer type
  logic        hwrite  = 1'b0;  // Write strobe
  logic [2:0]  hsize   = 3'h2;  // Word transfers only
  logic [31:0] hwdata  = '0;    // Write data
  logic [31:0] hrdata;          // Read data
  logic        hready;          // Ready, looped back
  logic        hresp;           // Response, checked once in t_reset
  logic        ev0, ev1;        // Event pins
  logic        g0, g1, osc;     // Gate pins, oscillator
  logic        irq;             // Interrupt line
  int          error_cnt = 0;   // Mismatches
  int          compares  = 0;   // Comparisons made

  // ----------------------------------------
  // Design, pin model, clock
  // ----------------------------------------
  tmb_top #(.PW(16)) uut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .TIMER0_EVENT_PIN(ev0), .TIMER1_EVENT_PIN(ev1),
    .TIMER0_GATE_INPUT(g0), .TIMER1_GATE_INPUT(g1),
    .EXT_OSC_CLK(osc), .IRQ(irq));
  tmb_pin_model pins (.clk(sys_clk), .ev0(ev0), .ev1(ev1),
    .timer0_hw_gating(g0), .gate1(g1), .osc(osc));
  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Report and compare helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  // Exact value
  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask
  // Value inside a window
  task automatic rng(input logic [31:0] g, lo, hi, input string m);
    compares++;
    if (^g === 1'bx || g < lo || g > hi) fail(m);
  endtask

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  // Bounded wait for ready at a rising edge
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail("bus hang");
      wrap_up();
    end
  endtask
  // One single word transfer
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask
  // Poll a status bit, bounded
  task automatic wait_stat(input int b);
    logic [31:0] d;
    for (int n = 0; n < 40; n++) begin
      rd(`TMB_A_STAT, d);
      if (d[b] === 1'b1) return;
    end
    fail("flag missing");
    wrap_up();
  endtask
  // Run a timer for 960 clocks and check its tick rate
  task automatic rate(input logic [31:0] ctl, ck, input logic [11:0] a,
                      input int dv);
    logic [31:0] d;
    wr(a, 32'h0000_0000);
    wr(`TMB_A_CLK, ck);
    wr(`TMB_A_CTRL, ctl);
    repeat (960) @(posedge sys_clk);
    wr(`TMB_A_CTRL, 32'h0000_0000);
    rd(a, d);
    rng(d, 960 / dv - 1, 966 / dv + 1, "tick rate");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values and an unmapped place
  task automatic t_reset();
    logic [31:0] d;
    rd(`TMB_A_CTRL, d);
    chk(d, 32'h0000_0000, "ctrl reset");
    rd(`TMB_A_STAT, d);
    chk(d, 32'h0000_0000, "stat reset");
    chk({31'h0, hresp}, 32'h0000_0000, "error response");
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, d);
    chk(d, 32'h0000_0000, "unmapped read");
  endtask
  // Clock sources of all four timers
  task automatic t_clock();
    wr(`TMB_A_MODE, 32'h0000_0005);
    rate(32'h0000_0001, 32'h0000_0000, `TMB_A_T0, 12);
    rate(32'h0000_0001, 32'h0000_0001, `TMB_A_T0, 4);
    rate(32'h0000_0001, 32'h0000_0002, `TMB_A_T0, 48);
    rate(32'h0000_0001, 32'h0000_0003, `TMB_A_T0, 32);
    rate(32'h0000_0001, 32'h0000_0004, `TMB_A_T0, 1);
    rate(32'h0000_0010, 32'h0000_0008, `TMB_A_T1, 1);
    rate(32'h0000_0010, 32'h0000_0001, `TMB_A_T1, 4);
    rate(32'h0000_0100, 32'h0000_0000, `TMB_A_T2, 1);
    rate(32'h0000_0100, 32'h0000_0010, `TMB_A_T2, 12);
    rate(32'h0000_0200, 32'h0000_0080, `TMB_A_T3, 32);
  endtask
  // 13-bit wrap, interrupt, clear; 16-bit carries on
  task automatic t_irq();
    logic [31:0] d;
    wr(`TMB_A_MODE, 32'h0000_0000);
    wr(`TMB_A_CLK, 32'h0000_0004);
    wr(`TMB_A_T0, 32'h0000_FFFE);
    wr(`TMB_A_CTRL, 32'h0000_0001);
    wait_stat(0);
    wr(`TMB_A_CTRL, 32'h0000_0000);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq while masked");
    wr(`TMB_A_MASK, 32'h0000_0001);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0001, "irq missing");
    wr(`TMB_A_STAT, 32'h0000_0001);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
    rd(`TMB_A_STAT, d);
    chk(d, 32'h0000_0000, "flag not cleared");
    wr(`TMB_A_MODE, 32'h0000_0001);
    wr(`TMB_A_T0, 32'h0000_0010);
    wr(`TMB_A_CTRL, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    wr(`TMB_A_CTRL, 32'h0000_0000);
    rd(`TMB_A_T0, d);
    rng(d, 32'h0000_0020, 32'h0000_0030, "16-bit count");
    wr(`TMB_A_MASK, 32'h0000_0000);
  endtask
  // 8-bit reload keeps the reload byte
  task automatic t_reload();
    logic [31:0] d;
    wr(`TMB_A_MASK, 32'h0000_0001);
    wr(`TMB_A_MODE, 32'h0000_0002);
    wr(`TMB_A_T0, 32'h0000_A0FD);
    wr(`TMB_A_CTRL, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    wr(`TMB_A_CTRL, 32'h0000_0000);
    rd(`TMB_A_T0, d);
    chk({24'h0, d[15:8]}, 32'h0000_00A0, "reload byte");
    rng({24'h0, d[7:0]}, 32'h0000_00A0, 32'h0000_00C0, "low");
    rd(`TMB_A_STAT, d);
    chk({31'h0, d[0]}, 32'h0000_0001, "reload flag");
    chk({31'h0, irq}, 32'h0000_0001, "reload irq");
    wr(`TMB_A_STAT, 32'h0000_003F);
    wr(`TMB_A_MASK, 32'h0000_0000);
  endtask
  // Gating by the gate pin and its active level
  task automatic t_gate();
    logic [31:0] d, e;
    wr(`TMB_A_MODE, 32'h0000_0001);
    wr(`TMB_A_T0, 32'h0000_0000);
    pins.gate(1'b0);
    wr(`TMB_A_CTRL, 32'h0000_0007);
    repeat (20) @(posedge sys_clk);
    rd(`TMB_A_T0, d);
    chk(d, 32'h0000_0000, "gate low counted");
    pins.gate(1'b1);
    repeat (20) @(posedge sys_clk);
    rd(`TMB_A_T0, d);
    rng(d, 32'h0000_000F, 32'h0000_0028, "gate high idle");
    wr(`TMB_A_CTRL, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    rd(`TMB_A_T0, d);
    repeat (20) @(posedge sys_clk);
    rd(`TMB_A_T0, e);
    chk(e, d, "inverse level counted");
    wr(`TMB_A_CTRL, 32'h0000_0000);
  endtask
  // Falling edges counted on both event pins
  task automatic t_count();
    logic [31:0] d;
    wr(`TMB_A_MODE, 32'h0000_0005);
    wr(`TMB_A_T0, 32'h0000_0000);
    wr(`TMB_A_T1, 32'h0000_0000);
    wr(`TMB_A_CTRL, 32'h0000_0099);
    pins.pulses(1'b0, 12, 2);
    pins.pulses(1'b1, 7, 2);
    repeat (8) @(posedge sys_clk);
    rd(`TMB_A_T0, d);
    chk(d, 32'h0000_000C, "pin0 edge count");
    rd(`TMB_A_T1, d);
    chk(d, 32'h0000_0007, "pin1 edge count");
    wr(`TMB_A_CTRL, 32'h0000_0000);
  endtask
  // Reload timer, 16-bit then split
  task automatic t_auto();
    logic [31:0] d;
    wr(`TMB_A_CLK, 32'h0000_0000);
    for (int s = 0; s < 2; s++) begin
      wr(`TMB_A_MODE, s ? 32'h0000_0015 : 32'h0000_0005);
      wr(`TMB_A_R2, s ? 32'h0000_00F0 : 32'h0000_1234);
      wr(`TMB_A_T2, s ? 32'h0000_00FE : 32'h0000_FFFE);
      wr(`TMB_A_CTRL, 32'h0000_0100);
      repeat (20) @(posedge sys_clk);
      wr(`TMB_A_CTRL, 32'h0000_0000);
      rd(`TMB_A_T2, d);
      if (s) rng({24'h0, d[7:0]}, 32'h0000_00F0, 32'h0000_00FF, "split");
      else rng(d, 32'h0000_1234, 32'h0000_1250, "16-bit reload");
      rd(`TMB_A_STAT, d);
      chk({31'h0, d[2]}, 32'h0000_0001, "reload flag");
      wr(`TMB_A_STAT, 32'h0000_003F);
    end
  endtask
  // Clock enable low freezes the count
  task automatic t_freeze();
    logic [31:0] d;
    wr(`TMB_A_T0, 32'h0000_0000);
    wr(`TMB_A_CLK, 32'h0000_0004);
    wr(`TMB_A_CTRL, 32'h0000_0001);
    clk_en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    clk_en <= 1'b1;
    wr(`TMB_A_CTRL, 32'h0000_0000);
    rd(`TMB_A_T0, d);
    rng(d, 32'h0000_0001, 32'h0000_0004, "frozen count");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_clock();
    t_irq();
    t_reload();
    t_gate();
    t_count();
    t_auto();
    t_freeze();
    wrap_up();
  end
endmodule // timer_bank_clocking_and_modes_tb_top
`default_nettype wire
